// ===== inc/rtc_defines.svh
/*
 Constants for the real-time clock: counter widths, divider ratio, trim span and alarm limits.
 Assumes inclusion by bare name from the design files; holds definitions only.
*/
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// ----------------------------------------------------------------
// Counter layout
// ----------------------------------------------------------------
`define RTC_SEC_W      32          // Absolute seconds width
`define RTC_SUB_W      12          // Sub-second field, 4096 steps a second
`define RTC_DIV_W      3           // Divide-by-eight prescaler bits
`define RTC_SSA_W      32          // Sub-second alarm interval width

// ----------------------------------------------------------------
// Time-of-day alarm limits, in seconds
// ----------------------------------------------------------------
`define RTC_TOD_W      21          // Interval field width
`define RTC_TOD_MIN_S  21'h000001  // 1 second
`define RTC_TOD_MAX_S  21'h0FD200  // 12 days = 1036800 seconds

// ----------------------------------------------------------------
// Rate trim
// ----------------------------------------------------------------
`define RTC_TRIM_W     8           // Signed ppm trim
`define RTC_TRIM_MAX   7'h7F       // 127 ppm magnitude limit
`define RTC_ACC_W      20          // Accumulator width for one million
`define RTC_PPM_SPAN   20'hF4240   // 1000000 crystal edges

`endif

// ===== inc/rtc_pkg.sv
/*
 Types shared by the real-time clock modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rtc_pkg;

	// Alarm life cycle
	typedef enum logic [1:0] {
		RTC_ALM_IDLE,
		RTC_ALM_ARMED,
		RTC_ALM_SPENT
	} rtc_alm_state_t;

endpackage : rtc_pkg

// ===== verilog/rtc_tick_gen.sv
/*
 Crystal edge detector with ppm rate trim.
 Assumes the crystal or external time base arrives asynchronously on a pin and is far
 slower than mclk_i (32.768 kHz against 100 MHz).
*/
`timescale 1ns/100ps
`include "rtc_defines.svh"

module rtc_tick_gen
(
	input  wire logic                   mclk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	input  wire logic                   xtal_i,   // Crystal time base pin
	input  wire logic [`RTC_TRIM_W-1:0] trim_i,   // Signed ppm trim
	output logic      [1:0]             step_o    // Prescaler steps this cycle: 0, 1 or 2
);

	// ----------------------------------------------------------------
	// Synchroniser and stable level
	// ----------------------------------------------------------------
	logic                  s1_q, s2_q, s3_q; // Three-stage pin synchroniser
	logic                  lvl_q;            // Accepted level
	logic                  rise;             // Accepted rising edge
	logic [`RTC_ACC_W-1:0] acc_q, acc_d;     // Error accumulator
	logic [6:0]            mag;              // Trim magnitude
	logic                  corr;             // Correction due this edge
	logic [`RTC_ACC_W:0]   sum;              // Widened accumulator sum

	// Only the second and third stages are compared
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_q  <= 1'h0;
			s2_q  <= 1'h0;
			s3_q  <= 1'h0;
			lvl_q <= 1'h0;
		end
		else if (ce_i)
		begin
			s1_q <= xtal_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// A change counts once two stages agree
			if (s2_q == s3_q)
			begin
				lvl_q <= s3_q;
			end
		end
	end

	assign rise = (s2_q == s3_q) && s3_q && !lvl_q;

	// ----------------------------------------------------------------
	// Trim: one extra or one dropped edge per million per ppm
	// ----------------------------------------------------------------
	// Magnitude clamped to 127; -128 would otherwise wrap to 0
	always_comb
	begin
		mag = trim_i[7] ? 7'((~trim_i) + 8'h01) : trim_i[6:0];
		if (trim_i == 8'h80)
		begin
			mag = `RTC_TRIM_MAX;
		end
		sum   = {1'h0, acc_q} + {14'h0000, mag};
		corr  = (sum >= {1'h0, `RTC_PPM_SPAN});
		acc_d = corr ? `RTC_ACC_W'(sum - {1'h0, `RTC_PPM_SPAN}) : sum[`RTC_ACC_W-1:0];
	end

	// Accumulator advances on each accepted edge
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			acc_q <= `RTC_ACC_W'h0;
		end
		else if (ce_i && rise)
		begin
			acc_q <= acc_d;
		end
	end

	// Positive trim doubles a step, negative drops one
	always_comb
	begin
		if (!ce_i || !rise)
		begin
			step_o = 2'h0;
		end
		else if (corr)
		begin
			step_o = trim_i[7] ? 2'h0 : 2'h2;
		end
		else
		begin
			step_o = 2'h1;
		end
	end

endmodule : rtc_tick_gen

// ===== verilog/rtc_alarm_cal.sv
/*
 Real-time clock: seconds counter, sub-second counter, two recurring alarms, rate trim
 and calibration output.
 Assumes a 32.768 kHz time base on slow_crystal_osc_i, a 100 MHz mclk_i kept alive in
 the low-power modes, and a power controller that reads irq_o and wake_o.
*/
`timescale 1ns/100ps
`include "rtc_defines.svh"

module rtc_alarm_cal
(
	input  wire logic                   mclk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	input  wire logic                   slow_crystal_osc_i, // 32.768 kHz time base
	input  wire logic                   rtc_en_i,           // Counting enable
	input  wire logic                   sec_load_i,         // Load seconds pulse
	input  wire logic [`RTC_SEC_W-1:0]  sec_val_i,          // Seconds load value
	input  wire logic [`RTC_TRIM_W-1:0] trim_i,             // Signed ppm trim
	input  wire logic                   tod_en_i,           // Time-of-day alarm enable
	input  wire logic                   tod_recur_i,        // Time-of-day alarm recurs
	input  wire logic [`RTC_TOD_W-1:0]  tod_ival_i,         // Seconds ahead
	input  wire logic                   ssa_en_i,           // Sub-second alarm enable
	input  wire logic                   ssa_recur_i,        // Sub-second alarm recurs
	input  wire logic [`RTC_SSA_W-1:0]  ssa_ival_i,         // 1/4096 s ahead
	input  wire logic                   tod_clr_i,          // Clear time-of-day flag
	input  wire logic                   ssa_clr_i,          // Clear sub-second flag
	input  wire logic                   irq_en_i,           // Route flags to interrupt
	input  wire logic                   wake_en_i,          // Route flags to wake
	input  wire logic                   cal_en_i,           // Calibration pin function
	output logic      [`RTC_SEC_W-1:0]  seconds_o,
	output logic      [`RTC_SUB_W-1:0]  subsec_o,
	output logic                        tod_flag_o,
	output logic                        ssa_flag_o,
	output logic                        irq_o,
	output logic                        wake_o,
	output logic                        rtc_cal_out_o,
	output logic                        rtc_cal_oe_o
);

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	logic [1:0]            step;        // Prescaler steps from trim stage
	logic [`RTC_DIV_W-1:0] div_q;       // Divide-by-eight prescaler
	logic [`RTC_SUB_W-1:0] sub_q;       // Sub-second counter
	logic [`RTC_SEC_W-1:0] sec_q;       // Absolute seconds
	logic [`RTC_DIV_W+`RTC_SUB_W:0] low_sum; // Prescaler and sub-second with carry
	logic                  sub_adv;     // Sub-second stepped this cycle
	logic                  sec_adv;     // Sub-second wrapped this cycle

	// Crystal edges, trimmed. Its rate sets the 4096 Hz step.
	rtc_tick_gen u_tick
	(
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.xtal_i (slow_crystal_osc_i),
		.trim_i (trim_i),
		.step_o (step)
	);

	// One wide add keeps the carry chain exact for double steps
	always_comb
	begin
		low_sum = {1'h0, sub_q, div_q} + {13'h0000, (rtc_en_i ? step : 2'h0)};
		sub_adv = (low_sum[`RTC_DIV_W+`RTC_SUB_W-1:`RTC_DIV_W] != sub_q) || low_sum[`RTC_DIV_W+`RTC_SUB_W];
		sec_adv = low_sum[`RTC_DIV_W+`RTC_SUB_W];
	end

	// Counting depends on rtc_en_i and ce_i only, never on the power mode
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			div_q <= `RTC_DIV_W'h0;
			sub_q <= `RTC_SUB_W'h0;
		end
		else if (ce_i)
		begin
			{sub_q, div_q} <= low_sum[`RTC_DIV_W+`RTC_SUB_W-1:0];
		end
	end

	// Seconds: load wins over counting
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sec_q <= `RTC_SEC_W'h0;
		end
		else if (ce_i)
		begin
			if (sec_load_i)
			begin
				sec_q <= sec_val_i;
			end
			else if (sec_adv)
			begin
				sec_q <= sec_q + `RTC_SEC_W'h1;
			end
		end
	end

	assign seconds_o = sec_q;
	assign subsec_o  = sub_q;

	// ----------------------------------------------------------------
	// Time-of-day alarm
	// ----------------------------------------------------------------
	rtc_pkg::rtc_alm_state_t tod_st_q;   // Alarm state
	logic [`RTC_SEC_W-1:0]   tod_tgt_q;  // Absolute target second
	logic [`RTC_TOD_W-1:0]   tod_iv;     // Clamped interval
	logic                    tod_hit;    // Target second reached

	// Out-of-range intervals are clamped rather than refused
	always_comb
	begin
		tod_iv = tod_ival_i;
		if (tod_ival_i < `RTC_TOD_MIN_S)
		begin
			tod_iv = `RTC_TOD_MIN_S;
		end
		else if (tod_ival_i > `RTC_TOD_MAX_S)
		begin
			tod_iv = `RTC_TOD_MAX_S;
		end
		tod_hit = (tod_st_q == rtc_pkg::RTC_ALM_ARMED) && sec_adv && !sec_load_i
		          && (sec_q + `RTC_SEC_W'h1 == tod_tgt_q);
	end

	// Arms on enable, target measured from the current second
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tod_st_q  <= rtc_pkg::RTC_ALM_IDLE;
			tod_tgt_q <= `RTC_SEC_W'h0;
		end
		else if (ce_i)
		begin
			unique case (tod_st_q)
				rtc_pkg::RTC_ALM_IDLE:
				begin
					if (tod_en_i)
					begin
						tod_tgt_q <= sec_q + `RTC_SEC_W'(tod_iv);
						tod_st_q  <= rtc_pkg::RTC_ALM_ARMED;
					end
				end
				rtc_pkg::RTC_ALM_ARMED:
				begin
					if (!tod_en_i)
					begin
						tod_st_q <= rtc_pkg::RTC_ALM_IDLE;
					end
					else if (tod_hit)
					begin
						// Recurring alarm rearms from the hit second
						if (tod_recur_i)
						begin
							tod_tgt_q <= tod_tgt_q + `RTC_SEC_W'(tod_iv);
						end
						else
						begin
							tod_st_q <= rtc_pkg::RTC_ALM_SPENT;
						end
					end
				end
				rtc_pkg::RTC_ALM_SPENT:
				begin
					// Software drops enable to arm again
					if (!tod_en_i)
					begin
						tod_st_q <= rtc_pkg::RTC_ALM_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sub-second alarm
	// ----------------------------------------------------------------
	rtc_pkg::rtc_alm_state_t ssa_st_q;   // Alarm state
	logic [`RTC_SSA_W-1:0]   ssa_cnt_q;  // Steps left
	logic [`RTC_SSA_W-1:0]   ssa_iv;     // Interval, at least one step
	logic                    ssa_hit;    // Last step taken

	always_comb
	begin
		ssa_iv  = (ssa_ival_i == `RTC_SSA_W'h0) ? `RTC_SSA_W'h1 : ssa_ival_i;
		ssa_hit = (ssa_st_q == rtc_pkg::RTC_ALM_ARMED) && sub_adv && (ssa_cnt_q == `RTC_SSA_W'h1);
	end

	// Counts down one per 1/4096 s step
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ssa_st_q  <= rtc_pkg::RTC_ALM_IDLE;
			ssa_cnt_q <= `RTC_SSA_W'h0;
		end
		else if (ce_i)
		begin
			unique case (ssa_st_q)
				rtc_pkg::RTC_ALM_IDLE:
				begin
					if (ssa_en_i)
					begin
						ssa_cnt_q <= ssa_iv;
						ssa_st_q  <= rtc_pkg::RTC_ALM_ARMED;
					end
				end
				rtc_pkg::RTC_ALM_ARMED:
				begin
					if (!ssa_en_i)
					begin
						ssa_st_q <= rtc_pkg::RTC_ALM_IDLE;
					end
					else if (ssa_hit)
					begin
						if (ssa_recur_i)
						begin
							ssa_cnt_q <= ssa_iv;
						end
						else
						begin
							ssa_st_q <= rtc_pkg::RTC_ALM_SPENT;
						end
					end
					else if (sub_adv)
					begin
						ssa_cnt_q <= ssa_cnt_q - `RTC_SSA_W'h1;
					end
				end
				rtc_pkg::RTC_ALM_SPENT:
				begin
					if (!ssa_en_i)
					begin
						ssa_st_q <= rtc_pkg::RTC_ALM_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flags, interrupt and wake
	// ----------------------------------------------------------------
	// Sticky flags; a hit in the clear cycle wins
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tod_flag_o <= 1'h0;
			ssa_flag_o <= 1'h0;
		end
		else if (ce_i)
		begin
			tod_flag_o <= tod_hit || (tod_flag_o && !tod_clr_i);
			ssa_flag_o <= ssa_hit || (ssa_flag_o && !ssa_clr_i);
		end
	end

	// Wake is combinational so it works with the core clock gated off
	assign irq_o  = irq_en_i && (tod_flag_o || ssa_flag_o);
	assign wake_o = wake_en_i && (tod_flag_o || ssa_flag_o);

	// ----------------------------------------------------------------
	// Calibration output
	// ----------------------------------------------------------------
	// Sub-second bit 0 gives 2048 Hz, so trim shows on the pin
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rtc_cal_out_o <= 1'h0;
			rtc_cal_oe_o  <= 1'h0;
		end
		else if (ce_i)
		begin
			rtc_cal_out_o <= cal_en_i && sub_q[0];
			rtc_cal_oe_o  <= cal_en_i;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	chk_sec_wrap:   assert property (ce_i && sec_adv && !sec_load_i |=> sec_q == $past(sec_q) + 32'h1)
		else $error("seconds did not step on wrap");
	chk_sub_rate:   assert property (ce_i && sub_adv |-> (div_q + {1'h0, step}) >= 4'h8 || !rtc_en_i)
		else $error("sub-second stepped early");
	chk_sec_only_wrap: assert property (ce_i && !sec_load_i && !sec_adv |=> $stable(sec_q))
		else $error("seconds moved without wrap");
	chk_tod_range:  assert property (tod_st_q == rtc_pkg::RTC_ALM_IDLE && tod_en_i && ce_i
		|=> (tod_tgt_q - $past(sec_q)) >= 32'h1 && (tod_tgt_q - $past(sec_q)) <= 32'h000FD200)
		else $error("time-of-day target out of span");
	chk_tod_hit:    assert property (ce_i && tod_hit |=> tod_flag_o)
		else $error("time-of-day flag missed");
	chk_ssa_hit:    assert property (ce_i && ssa_hit |=> ssa_flag_o)
		else $error("sub-second flag missed");
	chk_ssa_recur:  assert property (ce_i && ssa_hit && ssa_recur_i && ssa_en_i
		|=> ssa_st_q == rtc_pkg::RTC_ALM_ARMED && ssa_cnt_q == $past(ssa_iv))
		else $error("sub-second alarm did not rearm");
	chk_one_shot:   assert property (ce_i && tod_hit && !tod_recur_i |=> tod_st_q == rtc_pkg::RTC_ALM_SPENT)
		else $error("one-shot alarm still armed");
	chk_irq_route:  assert property (irq_o == (irq_en_i && (tod_flag_o || ssa_flag_o)))
		else $error("interrupt not gated by flags");
	chk_wake_hold:  assert property (wake_en_i && tod_flag_o && !tod_clr_i && ce_i |=> wake_en_i |-> wake_o)
		else $error("wake dropped while flag held");
	chk_cal_pin:    assert property (ce_i && !cal_en_i |=> !rtc_cal_oe_o && !rtc_cal_out_o)
		else $error("calibration pin driven while off");
	chk_run_on:     assert property (ce_i && rtc_en_i && step == 2'h1 |=> {sub_q, div_q} == $past({sub_q, div_q}) + 15'h1)
		else $error("counter stalled while enabled");
	chk_trim_gate:  assert property (ce_i && !rtc_en_i |=> $stable({sub_q, div_q}))
		else $error("counter moved while disabled");

	cov_tod_recur:  cover property (tod_hit && tod_recur_i ##[1:1000] tod_hit);
	cov_ssa_fire:   cover property (ssa_hit);
	cov_double:     cover property (step == 2'h2);
	cov_wake:       cover property (wake_o && !irq_o);

endmodule : rtc_alarm_cal

// ===== dv/rtc_xtal_model.sv
/*
 Behavioural 32.768 kHz time-base source for the real-time clock bench.
 Assumes mclk_i is the bench clock; the half period is given in mclk cycles,
 at least 4 so that the design's synchroniser sees every level.
*/
`timescale 1ns/100ps

module rtc_xtal_model
#(
	parameter int HALF_CYC = 4 // Mclk cycles per half period
)
(
	input  wire logic mclk_i,
	input  wire logic run_i,  // Oscillator running
	output logic      xtal_o  // Time-base pin
);
	// ------------------------------------------------------------
	// Square wave generator
	// ------------------------------------------------------------
	int cnt_q; // Cycles spent in current half period

	// Stopped oscillator rests low; a real crystal never floats mid-level
	always_ff @(posedge mclk_i)
	begin
		if (!run_i)
		begin
			cnt_q  <= 0;
			xtal_o <= 1'b0;
		end
		else if (cnt_q == HALF_CYC - 1)
		begin
			cnt_q  <= 0;
			xtal_o <= ~xtal_o;
		end
		else
		begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule : rtc_xtal_model

// ===== dv/rtc_alarm_calibration_tb_top.sv
/*
 Self-checking bench for the real-time clock: counting, both alarms, flags,
 interrupt and wake gating, seconds load and calibration pin.
 Assumes the crystal model runs 8 mclk per time-base period, so one
 sub-second step is 64 mclk; the one full-second wrap costs about 262k cycles.
*/
`timescale 1ns/100ps
`include "rtc_defines.svh"

module rtc_alarm_calibration_tb_top;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic                   mclk_i, rst_i, ce_i, xtal, rtc_en_i, sec_load_i;
	logic                   tod_en_i, tod_recur_i, ssa_en_i, ssa_recur_i;
	logic                   tod_clr_i, ssa_clr_i, irq_en_i, wake_en_i, cal_en_i;
	logic [`RTC_SEC_W-1:0]  sec_val_i, seconds_o;
	logic [`RTC_TRIM_W-1:0] trim_i;
	logic [`RTC_TOD_W-1:0]  tod_ival_i;
	logic [`RTC_SSA_W-1:0]  ssa_ival_i;
	logic [`RTC_SUB_W-1:0]  subsec_o, s0;
	logic                   tod_flag_o, ssa_flag_o, irq_o, wake_o, cal_o, cal_oe_o;
	int                     bad_count, comparisons, n;

	rtc_xtal_model #(.HALF_CYC(4)) rtc_xtal_model_inst (.mclk_i(mclk_i), .run_i(!rst_i), .xtal_o(xtal));

	rtc_alarm_cal rtc_alarm_cal_inst (
		.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .slow_crystal_osc_i(xtal),
		.rtc_en_i(rtc_en_i), .sec_load_i(sec_load_i), .sec_val_i(sec_val_i), .trim_i(trim_i),
		.tod_en_i(tod_en_i), .tod_recur_i(tod_recur_i), .tod_ival_i(tod_ival_i),
		.ssa_en_i(ssa_en_i), .ssa_recur_i(ssa_recur_i), .ssa_ival_i(ssa_ival_i),
		.tod_clr_i(tod_clr_i), .ssa_clr_i(ssa_clr_i), .irq_en_i(irq_en_i), .wake_en_i(wake_en_i),
		.cal_en_i(cal_en_i), .seconds_o(seconds_o), .subsec_o(subsec_o), .tod_flag_o(tod_flag_o),
		.ssa_flag_o(ssa_flag_o), .irq_o(irq_o), .wake_o(wake_o), .rtc_cal_out_o(cal_o),
		.rtc_cal_oe_o(cal_oe_o));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// One compare, counted; mismatch reported at once
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Wait for the next sub-second step, bounded; n returns cycles spent
	task automatic wait_step();
		logic [`RTC_SUB_W-1:0] s;
		s = subsec_o;
		n = 0;
		while (subsec_o === s && n < 200)
		begin
			@(negedge mclk_i);
			n++;
		end
	endtask : wait_step

	// Wait for a flag, bounded; the caller checks the outcome
	task automatic wait_flag(input logic ssa, input int lim);
		n = 0;
		while ((ssa ? ssa_flag_o : tod_flag_o) !== 1'b1 && n < lim)
		begin
			@(negedge mclk_i);
			n++;
		end
	endtask : wait_flag

	// Pulse the sub-second flag clear for one cycle
	task automatic clr_ssa();
		@(posedge mclk_i);
		ssa_clr_i <= 1'b1;
		@(posedge mclk_i);
		ssa_clr_i <= 1'b0;
		@(negedge mclk_i);
	endtask : clr_ssa

	// Load the seconds counter through the load pulse
	task automatic load_sec(input logic [`RTC_SEC_W-1:0] v);
		@(posedge mclk_i);
		sec_load_i <= 1'b1;
		sec_val_i  <= v;
		@(posedge mclk_i);
		sec_load_i <= 1'b0;
		@(negedge mclk_i);
	endtask : load_sec

	// Single exit point with counts and verdict
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	// Whole sequence needs about 265k cycles; margin for a slow design
	initial
	begin
		repeat (400000) @(posedge mclk_i);
		bad_count++;
		final_report();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		{rtc_en_i, sec_load_i, tod_en_i, tod_recur_i, ssa_en_i, ssa_recur_i} = '0;
		{tod_clr_i, ssa_clr_i, irq_en_i, wake_en_i, cal_en_i} = '0;
		sec_val_i = '0;
		trim_i = 8'h00;
		tod_ival_i = '0;
		ssa_ival_i = '0;
		bad_count = 0;
		comparisons = 0;
		ce_i = 1'b1;
		rst_i = 1'b1;
		repeat (3) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(negedge mclk_i);
		check(seconds_o, 32'h0);
		check({subsec_o, tod_flag_o, ssa_flag_o, irq_o, wake_o, cal_o, cal_oe_o}, 32'h0);
		// Counting disabled: nothing moves
		repeat (200) @(negedge mclk_i);
		check(subsec_o, 32'h0);
		$display("test reset done");

		// Step rate: eight time-base edges per sub-second step
		@(posedge mclk_i);
		rtc_en_i <= 1'b1;
		wait_step();
		s0 = subsec_o;
		wait_step();
		check(n, 32'h40);
		check(subsec_o, s0 + 12'h001);
		$display("test step rate done");

		// Calibration pin follows the 2048 Hz bit while enabled
		@(posedge mclk_i);
		cal_en_i <= 1'b1;
		repeat (3) @(negedge mclk_i);
		check({cal_oe_o, cal_o}, {1'b1, subsec_o[0]});
		wait_step();
		repeat (3) @(negedge mclk_i);
		check({cal_oe_o, cal_o}, {1'b1, subsec_o[0]});
		@(posedge mclk_i);
		cal_en_i <= 1'b0;
		repeat (3) @(negedge mclk_i);
		check({cal_oe_o, cal_o}, 32'h0);
		$display("test calibration done");

		// One-shot sub-second alarm three steps ahead, routed to interrupt
		wait_step();
		@(posedge mclk_i);
		ssa_en_i   <= 1'b1;
		ssa_ival_i <= 32'h3;
		irq_en_i   <= 1'b1;
		s0 = subsec_o;
		wait_flag(1'b1, 260);
		check(ssa_flag_o, 1'b1);
		check(subsec_o, s0 + 12'h003);
		check({irq_o, wake_o}, 2'b10);
		clr_ssa();
		check({ssa_flag_o, irq_o}, 2'b00);
		repeat (300) @(negedge mclk_i);
		check(ssa_flag_o, 1'b0);
		$display("test sub-second one-shot done");

		// Recurring sub-second alarm, interval 0 acts as 1, routed to wake
		@(posedge mclk_i);
		ssa_en_i <= 1'b0;
		irq_en_i <= 1'b0;
		wake_en_i <= 1'b1;
		wait_step();
		@(posedge mclk_i);
		ssa_en_i    <= 1'b1;
		ssa_recur_i <= 1'b1;
		ssa_ival_i  <= 32'h0;
		s0 = subsec_o;
		wait_flag(1'b1, 100);
		check(subsec_o, s0 + 12'h001);
		check({irq_o, wake_o}, 2'b01);
		clr_ssa();
		wait_flag(1'b1, 100);
		check(subsec_o, s0 + 12'h002);
		@(posedge mclk_i);
		ssa_en_i <= 1'b0;
		clr_ssa();
		$display("test sub-second recur done");

		// Seconds load; a load reaching the target must not fire
		load_sec(32'hFFFF_FFFE);
		check(seconds_o, 32'hFFFF_FFFE);
		@(posedge mclk_i);
		tod_en_i   <= 1'b1;
		tod_ival_i <= 21'h000005;
		@(negedge mclk_i);
		load_sec(32'h0000_0003);
		repeat (100) @(negedge mclk_i);
		check(tod_flag_o, 1'b0);
		$display("test load no fire done");

		// Interval 0 clamps to one second; fires on the wrap into the target
		@(posedge mclk_i);
		tod_en_i <= 1'b0;
		load_sec(32'hFFFF_FFFE);
		@(posedge mclk_i);
		tod_en_i   <= 1'b1;
		tod_ival_i <= 21'h000000;
		wait_flag(1'b0, 270000);
		check(tod_flag_o, 1'b1);
		check(seconds_o, 32'hFFFF_FFFF);
		check(subsec_o, 32'h0);
		check(wake_o, 1'b1);
		$display("test time-of-day alarm done");
		final_report();
	end
endmodule : rtc_alarm_calibration_tb_top
